/* File: evu_exception_vector_unit.sv */
/*
  Exception and interrupt dispatch: ranks one event per cycle, records its
  cause, saves the restart pc and redirects fetch. Assumes the pipeline
  presents current and next pc with each request and holds a request
  until it is taken; a handler return in a cycle with no accepted event clears the nmi in-handler flag if set, else the maskable one.
*/
`timescale 1ns/1ps
module evu_exception_vector_unit
  import evu_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic NMI_I,
  input wire logic INT_REQ_I,
  input wire logic [3:0] INT_LEVEL_I,
  input wire logic [EX_W-1:0] EXC_REQ_I,
  input wire logic [4:0] TRAP_PARAM_I,
  input wire logic LONG_OP_I,
  input wire logic [31:0] CUR_PC_I,
  input wire logic [31:0] NEXT_PC_I,
  input wire logic RETURN_I,
  output logic REDIRECT_O,
  output logic [31:0] REDIRECT_PC_O,
  output logic [31:0] EVENT_CAUSE_REG_O,
  output logic [31:0] MASKABLE_RESTART_PC_O,
  output logic [31:0] NONMASKABLE_RESTART_PC_O,
  output logic [31:0] STATUS_WORD_O,
  output logic ABORT_O,
  output logic IN_HANDLER_O
);
  // ==========================================================
  // nmi pin sampling: three flops, change once second and third agree
  logic [2:0] nmi_sync_q;
  logic nmi_lvl_q;
  logic nmi_prev_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nmi_sync_q <= 3'h0;
      nmi_lvl_q <= 1'b0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], NMI_I};
      if (nmi_sync_q[1] == nmi_sync_q[2]) begin
        nmi_lvl_q <= nmi_sync_q[2];
      end
    end
  end

  // ==========================================================
  // event ranking, combinational
  logic in_exc_q;
  logic in_nmi_q;
  logic nmi_pend_q;
  wire nmi_edge = nmi_lvl_q & ~nmi_prev_q;
  wire nmi_now = (nmi_edge | nmi_pend_q) & ~in_nmi_q;
  // RULE15 underflow and precision dropped
  wire [EX_W-1:0] fp_never_mask = (10'h1 << EX_FP_UNDERFLOW) | (10'h1 << EX_FP_PRECISION);
  wire [EX_W-1:0] exc_live = EXC_REQ_I & ~fp_never_mask;
  wire exc_any = |exc_live;
  wire int_now = INT_REQ_I & ~in_exc_q;

  // code and vector lookup for the highest ranked exception
  function automatic logic [47:0] exc_lookup(input logic [EX_W-1:0] r, input logic [4:0] tp);
    logic [47:0] res;
    res = {CODE_FP_RESERVED, VEC_FP};
    if (r[EX_FP_RESERVED]) res = {CODE_FP_RESERVED, VEC_FP};
    if (r[EX_FP_OVERFLOW]) res = {CODE_FP_OVERFLOW, VEC_FP};
    if (r[EX_FP_DIVZERO]) res = {CODE_FP_DIVZERO, VEC_FP};
    if (r[EX_FP_INVALID]) res = {CODE_FP_INVALID, VEC_FP};
    if (r[EX_TRAP]) res = tp[4] ? {CODE_TRAP1 | {12'h0, tp[3:0]}, VEC_TRAP1}
                                : {CODE_TRAP0 | {12'h0, tp[3:0]}, VEC_TRAP0};
    if (r[EX_DIVZ]) res = {CODE_DIVZ, VEC_DIVZ};
    if (r[EX_ILLOP]) res = {CODE_ILLOP, VEC_ILLOP};
    if (r[EX_ADTRAP]) res = {CODE_ADTRAP, VEC_ADTRAP};
    return res;
  endfunction : exc_lookup

  wire [47:0] exc_cv = exc_lookup(exc_live, TRAP_PARAM_I);
  wire exc_is_trap = exc_live[EX_TRAP] & ~|exc_live[EX_DIVZ:EX_ADTRAP];
  wire [15:0] int_code = CODE_INT | (16'(INT_LEVEL_I) << LVL_LSB);
  wire [31:0] int_vec = VEC_INT | (32'(INT_LEVEL_I) << LVL_LSB);
  // RULE6 aborted long operation restarts itself
  wire [31:0] int_rpc = LONG_OP_I ? CUR_PC_I : NEXT_PC_I;
  // RULE9 RULE10 traps resume after the trap
  wire [31:0] exc_rpc = exc_is_trap ? NEXT_PC_I : CUR_PC_I;
  // RULE1 interrupts outrank exceptions
  wire take_nmi = nmi_now;
  wire take_int = ~take_nmi & int_now;
  wire take_dbl = ~take_nmi & ~take_int & exc_any & in_exc_q;
  wire take_exc = ~take_nmi & ~take_int & exc_any & ~in_exc_q;
  wire take_any = take_nmi | take_int | take_dbl | take_exc;

  // ==========================================================
  // state update: cause, save registers and redirect move together
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [31:0] mpc_q;
  logic [31:0] npc_q;
  logic redir_q;
  logic [31:0] rpc_q;
  logic abort_q;
  logic [31:0] status_q;
  // registered copy of the handler flags so the pin comes from one flop
  logic in_hand_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      // RULE4 RULE17 reset values; save pcs held at zero for determinism
      upper_q <= UPPER_RST;
      lower_q <= CODE_RESET;
      mpc_q <= PC_RST;
      npc_q <= PC_RST;
      redir_q <= 1'b0;
      rpc_q <= VEC_RESET;
      abort_q <= 1'b0;
      status_q <= STATUS_WORD_RST;
      in_hand_q <= 1'b0;
      in_exc_q <= 1'b0;
      in_nmi_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_lvl_q;
      // an edge while an nmi handler runs waits; set wins over clear
      nmi_pend_q <= (nmi_edge & in_nmi_q) | (nmi_pend_q & ~take_nmi);
      // RULE18 single accepted event per cycle
      redir_q <= take_any;
      abort_q <= take_int & LONG_OP_I;
      if (take_nmi) begin
        // RULE16 nmi code in upper half
        upper_q <= CODE_NMI;
        npc_q <= NEXT_PC_I;
        rpc_q <= VEC_NMI;
        in_nmi_q <= 1'b1;
        in_hand_q <= 1'b1;
      end else if (take_int) begin
        // RULE5 RULE3 maskable level code and vector
        lower_q <= int_code;
        mpc_q <= int_rpc;
        rpc_q <= int_vec;
        in_exc_q <= 1'b1;
        in_hand_q <= 1'b1;
      end else if (take_dbl) begin
        // RULE8 second code upper, first kept, nmi handler
        upper_q <= exc_cv[47:32];
        npc_q <= CUR_PC_I;
        rpc_q <= VEC_NMI;
        in_nmi_q <= 1'b1;
        in_hand_q <= 1'b1;
      end else if (take_exc) begin
        // RULE2 RULE7 RULE11 RULE12 RULE13 RULE14 source-fixed vector
        lower_q <= exc_cv[47:32];
        mpc_q <= exc_rpc;
        rpc_q <= exc_cv[31:0];
        in_exc_q <= 1'b1;
        in_hand_q <= 1'b1;
      end else if (RETURN_I) begin
        // return leaves the nmi handler first
        if (in_nmi_q) in_nmi_q <= 1'b0;
        else in_exc_q <= 1'b0;
        // still inside the outer handler only if both were active
        in_hand_q <= in_nmi_q & in_exc_q;
      end
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign REDIRECT_O = redir_q;
  assign REDIRECT_PC_O = rpc_q;
  assign EVENT_CAUSE_REG_O = {upper_q, lower_q};
  assign MASKABLE_RESTART_PC_O = mpc_q;
  assign NONMASKABLE_RESTART_PC_O = npc_q;
  assign STATUS_WORD_O = status_q;
  assign ABORT_O = abort_q;
  assign IN_HANDLER_O = in_hand_q;

  // ==========================================================
  // checks
  property p_int_first;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (INT_REQ_I && !in_exc_q && !nmi_now && exc_any) |=> (lower_q[15:8] == CODE_INT[15:8]);
  endproperty
  a_int_first: assert property (p_int_first) else $error("exception beat interrupt"); // RULE1
  property p_vec_int;
    @(posedge CLK_I) disable iff (!RST_N_I)
      take_int |=> REDIRECT_O && REDIRECT_PC_O == {VEC_INT[31:8], $past(INT_LEVEL_I), 4'h0};
  endproperty
  a_vec_int: assert property (p_vec_int) else $error("wrong interrupt vector"); // RULE5
  property p_abort_pc;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (take_int && LONG_OP_I) |=> MASKABLE_RESTART_PC_O == $past(CUR_PC_I) && ABORT_O;
  endproperty
  a_abort_pc: assert property (p_abort_pc) else $error("aborted op pc wrong"); // RULE6
  property p_dbl;
    @(posedge CLK_I) disable iff (!RST_N_I)
      take_dbl |=> REDIRECT_PC_O == VEC_NMI && lower_q == $past(lower_q);
  endproperty
  a_dbl: assert property (p_dbl) else $error("double fault handling wrong"); // RULE8
  property p_trap_pc;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (take_exc && exc_is_trap) |=> MASKABLE_RESTART_PC_O == $past(NEXT_PC_I);
  endproperty
  a_trap_pc: assert property (p_trap_pc) else $error("trap restart pc wrong"); // RULE9
  property p_illop;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (take_exc && exc_live[EX_ILLOP] && !exc_live[EX_ADTRAP]) |=> lower_q == CODE_ILLOP;
  endproperty
  a_illop: assert property (p_illop) else $error("invalid opcode code wrong"); // RULE11
  property p_fp_vec;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (take_exc && exc_live[EX_TRAP:EX_ADTRAP] == 4'h0) |=> REDIRECT_PC_O == VEC_FP;
  endproperty
  a_fp_vec: assert property (p_fp_vec) else $error("fp vector wrong"); // RULE12
  property p_no_fp_lost;
    @(posedge CLK_I) disable iff (!RST_N_I)
      1'b1 |-> lower_q != CODE_FP_UNDERFLOW && lower_q != CODE_FP_PRECISION;
  endproperty
  a_no_fp_lost: assert property (p_no_fp_lost) else $error("forbidden fp code"); // RULE15
  property p_one_event;
    @(posedge CLK_I) disable iff (!RST_N_I)
      !take_any |=> !REDIRECT_O ##0 EVENT_CAUSE_REG_O == $past(EVENT_CAUSE_REG_O);
  endproperty
  a_one_event: assert property (p_one_event) else $error("state changed without event"); // RULE18
  c_nmi: cover property (@(posedge CLK_I) disable iff (!RST_N_I) take_nmi);
  c_int: cover property (@(posedge CLK_I) disable iff (!RST_N_I) take_int && LONG_OP_I);
  c_dbl: cover property (@(posedge CLK_I) disable iff (!RST_N_I) take_dbl);
  c_trap: cover property (@(posedge CLK_I) disable iff (!RST_N_I) take_exc && exc_is_trap);
  c_nested_ret: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    RETURN_I && in_nmi_q && in_exc_q);
endmodule : evu_exception_vector_unit

/* File: evu_pkg.sv */
/*
  Constants for the exception and interrupt dispatch unit: cause codes,
  handler addresses, reset values. Assumes a 32-bit core with a 16-bit
  cause code per event.
*/
// Functional notes
// RULE1: interrupt beats exception when both pending
// RULE2: handler address fixed by event source
// RULE3: cause code written on each accepted event
// RULE4: reset is code fff0, start fffffff0
// RULE5: maskable level n: code fen0, next pc
// RULE6: long instruction aborted saves its own pc
// RULE7: save to maskable or nonmaskable pc; address trap
// RULE8: double fault: codes split, nmi handler
// RULE9: trap 0x1n: code ffbn, next pc
// RULE10: trap 0x0n: code ffan, next pc
// RULE11: invalid opcode ff90, zero divide ff80
// RULE12: fp invalid ff70, fp handler ff60
// RULE13: fp divide by zero ff68
// RULE14: fp overflow ff64, reserved operand ff60
// RULE15: fp underflow and precision never raised
// RULE16: cause upper half nmi/double, lower ordinary
// RULE17: reset pc, status word and cause values
// RULE18: one event per cycle, all updated together
package evu_pkg;
  // ==========================================================
  // cause codes
  localparam logic [15:0] CODE_RESET = 16'hfff0;
  localparam logic [15:0] CODE_NMI = 16'hffd0;
  localparam logic [15:0] CODE_ADTRAP = 16'hffc0;
  localparam logic [15:0] CODE_TRAP1 = 16'hffb0;
  localparam logic [15:0] CODE_TRAP0 = 16'hffa0;
  localparam logic [15:0] CODE_ILLOP = 16'hff90;
  localparam logic [15:0] CODE_DIVZ = 16'hff80;
  localparam logic [15:0] CODE_FP_INVALID = 16'hff70;
  localparam logic [15:0] CODE_FP_DIVZERO = 16'hff68;
  localparam logic [15:0] CODE_FP_OVERFLOW = 16'hff64;
  localparam logic [15:0] CODE_FP_UNDERFLOW = 16'hff62;
  localparam logic [15:0] CODE_FP_PRECISION = 16'hff61;
  localparam logic [15:0] CODE_FP_RESERVED = 16'hff60;
  localparam logic [15:0] CODE_INT = 16'hfe00;
  // ==========================================================
  // handler addresses
  localparam logic [31:0] VEC_RESET = 32'hfffffff0;
  localparam logic [31:0] VEC_NMI = 32'hffffffd0;
  localparam logic [31:0] VEC_ADTRAP = 32'hffffffc0;
  localparam logic [31:0] VEC_TRAP1 = 32'hffffffb0;
  localparam logic [31:0] VEC_TRAP0 = 32'hffffffa0;
  localparam logic [31:0] VEC_ILLOP = 32'hffffff90;
  localparam logic [31:0] VEC_DIVZ = 32'hffffff80;
  localparam logic [31:0] VEC_FP = 32'hffffff60;
  localparam logic [31:0] VEC_INT = 32'hfffffe00;
  // ==========================================================
  // field positions and reset values
  localparam int LVL_LSB = 4;
  localparam logic [31:0] STATUS_WORD_RST = 32'h00008000;
  localparam logic [15:0] UPPER_RST = 16'h0000;
  localparam logic [31:0] PC_RST = 32'h0;
  // exception request bit order, fixed priority low index first
  localparam int EX_ADTRAP = 0;
  localparam int EX_ILLOP = 1;
  localparam int EX_DIVZ = 2;
  localparam int EX_TRAP = 3;
  localparam int EX_FP_INVALID = 4;
  localparam int EX_FP_DIVZERO = 5;
  localparam int EX_FP_OVERFLOW = 6;
  localparam int EX_FP_RESERVED = 7;
  localparam int EX_FP_UNDERFLOW = 8;
  localparam int EX_FP_PRECISION = 9;
  localparam int EX_W = 10;
endpackage : evu_pkg

/* File: evu_pipe_model.sv */
/*
  Pipeline stand-in for the dispatch unit: presents one-cycle event requests
  with their qualifiers and the current and next pc.
  Assumes the bench raises fire_i by nonblocking assignment at a falling edge.
*/
`timescale 1ns/1ps
module evu_pipe_model
  import evu_pkg::*;
#(
  parameter logic [31:0] CUR_PC = 32'h00001230,
  parameter logic [31:0] NEXT_PC = 32'h00001234
) (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [EX_W-1:0] exc_i,
  input wire logic int_i,
  input wire logic [3:0] lvl_i,
  input wire logic [4:0] prm_i,
  input wire logic long_i,
  output logic [EX_W-1:0] exc_o,
  output logic int_o,
  output logic [3:0] lvl_o,
  output logic [4:0] prm_o,
  output logic long_o,
  output logic [31:0] cur_pc_o,
  output logic [31:0] next_pc_o
);
  // ==========================================================
  // request stage
  initial begin
    {exc_o, int_o, lvl_o, prm_o, long_o} = '0;
  end
  // level and trap parameter flip when idle so a stale level is never mistaken for data; long clears
  always @(negedge clk_i) begin
    exc_o <= fire_i ? exc_i : '0;
    int_o <= fire_i ? int_i : 1'b0;
    lvl_o <= fire_i ? lvl_i : ~lvl_o;
    prm_o <= fire_i ? prm_i : ~prm_o;
    long_o <= fire_i ? long_i : 1'b0;
  end
  assign cur_pc_o = CUR_PC;
  assign next_pc_o = NEXT_PC;
endmodule : evu_pipe_model

/* File: evu_exception_vector_unit_tb.sv */
/*
  Self-checking bench for the dispatch unit: one task per event kind.
  Assumes the pipeline model drops each request after one cycle.
*/
`timescale 1ns/1ps
module evu_exception_vector_unit_tb;
  import evu_pkg::*;
  localparam logic [31:0] CPC = 32'h00001230;
  localparam logic [31:0] NPC = 32'h00001234;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic nmi = 1'b0, fire = 1'b0, ret = 1'b0, lng = 1'b0, intr = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [4:0] prm = 5'h00;
  logic [EX_W-1:0] exc = '0;
  logic [EX_W-1:0] m_exc;
  logic m_int, m_long, rd, abrt, ihd;
  logic [3:0] m_lvl;
  logic [4:0] m_prm;
  logic [31:0] m_cur, m_nxt, rpc, cause, mpc, npc, sw;
  int fail_count = 0;
  int cmp_count = 0;
  // ==========================================================
  // clock and instances
  always #5 clk_i = ~clk_i;
  evu_pipe_model #(.CUR_PC(CPC), .NEXT_PC(NPC)) u_evu_pipe_model (.clk_i(clk_i),
    .fire_i(fire), .exc_i(exc), .int_i(intr), .lvl_i(lvl), .prm_i(prm), .long_i(lng),
    .exc_o(m_exc), .int_o(m_int), .lvl_o(m_lvl), .prm_o(m_prm), .long_o(m_long),
    .cur_pc_o(m_cur), .next_pc_o(m_nxt));
  evu_exception_vector_unit u_evu_exception_vector_unit (.CLK_I(clk_i), .RST_N_I(rst_n_i),
    .NMI_I(nmi), .INT_REQ_I(m_int), .INT_LEVEL_I(m_lvl), .EXC_REQ_I(m_exc),
    .TRAP_PARAM_I(m_prm), .LONG_OP_I(m_long), .CUR_PC_I(m_cur), .NEXT_PC_I(m_nxt),
    .RETURN_I(ret), .REDIRECT_O(rd), .REDIRECT_PC_O(rpc), .EVENT_CAUSE_REG_O(cause),
    .MASKABLE_RESTART_PC_O(mpc), .NONMASKABLE_RESTART_PC_O(npc), .STATUS_WORD_O(sw),
    .ABORT_O(abrt), .IN_HANDLER_O(ihd));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // optional handler returns, one-cycle request, bounded wait for redirect
  task automatic ev(input logic [9:0] e, input logic i, input logic [3:0] l,
                    input logic [4:0] p, input logic lg, input logic r);
    int n;
    if (r) repeat (2) begin
      @(negedge clk_i) ret <= 1'b1;
      @(negedge clk_i) ret <= 1'b0;
    end
    @(negedge clk_i) {exc, intr, lvl, prm, lng, fire} <= {e, i, l, p, lg, 1'b1};
    @(negedge clk_i) fire <= 1'b0;
    n = 0;
    while (rd !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
  endtask : ev
  task automatic ck(input logic [31:0] v, input logic [15:0] c, input logic [31:0] pc);
    chk("redirect", {31'h0, rd}, 32'h1);
    chk("vector", rpc, v);
    chk("cause_low", {16'h0, cause[15:0]}, {16'h0, c});
    chk("restart_pc", mpc, pc);
  endtask : ck
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("reset_cause", cause, 32'h0000fff0);
    chk("reset_vector", rpc, 32'hfffffff0);
    chk("status_word", sw, 32'h00008000);
  endtask : t_reset
  task automatic t_codes();
    ev(10'h002, 0, 0, 0, 0, 1); ck(32'hffffff90, 16'hff90, CPC);
    ev(10'h004, 0, 0, 0, 0, 1); ck(32'hffffff80, 16'hff80, CPC);
    ev(10'h001, 0, 0, 0, 0, 1); ck(32'hffffffc0, 16'hffc0, CPC);
    ev(10'h008, 0, 0, 5'h15, 0, 1); ck(32'hffffffb0, 16'hffb5, NPC);
    ev(10'h008, 0, 0, 5'h03, 0, 1); ck(32'hffffffa0, 16'hffa3, NPC);
    ev(10'h010, 0, 0, 0, 0, 1); ck(32'hffffff60, 16'hff70, CPC);
    ev(10'h020, 0, 0, 0, 0, 1); ck(32'hffffff60, 16'hff68, CPC);
    ev(10'h040, 0, 0, 0, 0, 1); ck(32'hffffff60, 16'hff64, CPC);
    ev(10'h080, 0, 0, 0, 0, 1); ck(32'hffffff60, 16'hff60, CPC);
    @(negedge clk_i);
    chk("redirect_pulse", {31'h0, rd}, 32'h0);
  endtask : t_codes
  task automatic t_ints();
    ev(10'h000, 1, 4'h0, 0, 0, 1); ck(32'hfffffe00, 16'hfe00, NPC);
    chk("no_abort", {31'h0, abrt}, 32'h0);
    ev(10'h000, 1, 4'hf, 0, 0, 1); ck(32'hfffffef0, 16'hfef0, NPC);
    ev(10'h000, 1, 4'h9, 0, 1, 1); ck(32'hfffffe90, 16'hfe90, CPC);
    chk("abort", {31'h0, abrt}, 32'h1);
    ev(10'h002, 1, 4'h7, 0, 0, 1); ck(32'hfffffe70, 16'hfe70, NPC);
  endtask : t_ints
  // underflow and precision-loss requests must never redirect
  task automatic t_never();
    ev(10'h100, 0, 0, 0, 0, 1);
    chk("no_redirect_fud", {31'h0, rd}, 32'h0);
    ev(10'h200, 0, 0, 0, 0, 0);
    chk("no_redirect_fpr", {31'h0, rd}, 32'h0);
    chk("in_handler_idle", {31'h0, ihd}, 32'h0);
  endtask : t_never
  // second exception before the first handler returns
  task automatic t_double();
    ev(10'h002, 0, 0, 0, 0, 1);
    ev(10'h004, 0, 0, 0, 0, 0);
    chk("double_cause", cause, 32'hff80ff90);
    chk("double_vector", rpc, 32'hffffffd0);
    chk("double_pc", npc, CPC);
    chk("double_in_handler", {31'h0, ihd}, 32'h1);
  endtask : t_double
  task automatic t_nmi();
    int n;
    repeat (2) @(negedge clk_i) ret <= ~ret;
    @(negedge clk_i) nmi <= 1'b1;
    n = 0;
    while (rd !== 1'b1 && n < 12) begin
      @(negedge clk_i);
      n++;
    end
    chk("nmi_cause_high", {16'h0, cause[31:16]}, 32'h0000ffd0);
    chk("nmi_vector", rpc, 32'hffffffd0);
    chk("nmi_pc", npc, NPC);
    @(negedge clk_i) nmi <= 1'b0;
  endtask : t_nmi
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(negedge clk_i);
    t_reset();
    rst_n_i <= 1'b1;
    t_codes();
    t_ints();
    t_never();
    t_double();
    t_nmi();
    tally_and_finish();
  end
  // roughly twenty events of about seven cycles each; far beyond that is a hang
  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end
endmodule : evu_exception_vector_unit_tb
